/* File: design/telemetry_fault_nvm_regs.sv */
// Telemetry, fault status and nonvolatile program register bank behind the serial engine
`timescale 1ns/1ps
module telemetry_fault_nvm_regs
    import telemetry_pkg::*;
#(
    parameter int PRECISE_PERIOD_CYCLES = PRECISE_CYCLES,
    parameter int HEAT_PERIOD_CYCLES = PRECISE_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port from the serial protocol engine
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Converter results
    input wire logic [7:0] quick_adc_code,
    input wire logic [11:0] precise_adc_code,
    input wire logic [11:0] heat_adc_code,
    // Protection detectors
    input wire logic die_overheat_flag,
    input wire logic output_overload_flag,
    input wire logic output_short_flag,
    // Configuration bytes to burn
    output logic [3:0] cfg_read_index,
    input wire logic [7:0] cfg_read_data,
    output logic [3:0] inductor_resistance_code,
    // Nonvolatile memory write port
    output logic nvm_write_req,
    output logic [3:0] nvm_write_addr,
    output logic [7:0] nvm_write_data,
    input wire logic nvm_write_ack
);
    localparam logic [TIMER_WIDTH-1:0] QUICK_LAST = TIMER_WIDTH'(QUICK_CYCLES - 1);
    localparam logic [TIMER_WIDTH-1:0] PRECISE_LAST = TIMER_WIDTH'(PRECISE_PERIOD_CYCLES - 1);
    localparam logic [TIMER_WIDTH-1:0] HEAT_LAST = TIMER_WIDTH'(HEAT_PERIOD_CYCLES - 1);

    logic [TIMER_WIDTH-1:0] quick_timer_reg;
    logic [TIMER_WIDTH-1:0] precise_timer_reg;
    logic [TIMER_WIDTH-1:0] heat_timer_reg;
    logic quick_tick;
    logic [7:0] quick_current_result_reg;
    logic [2:0] fault_flags_reg;
    logic [4:0] nvm_program_command_reg;
    logic nvm_program_done_reg;
    logic [7:0] nvm_unlock_key_reg;
    logic [3:0] res_code_reg;
    logic [3:0] burn_index_reg;
    logic [7:0] burn_data_reg;
    burn_state_t burn_state_reg;
    burn_state_t burn_state_next;
    logic write_program;
    logic command_hit;
    logic unlocked;
    logic program_accept;
    logic burn_last;
    logic [7:0] read_mux;

    split_result_if precise_bus ();
    split_result_if heat_bus ();

    // Conversion timers; each result has its own cadence
    always_ff @(posedge clock) begin
        if (rst) begin
            quick_timer_reg <= '0;
        end else if (quick_tick) begin
            quick_timer_reg <= '0;
        end else begin
            quick_timer_reg <= quick_timer_reg + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst || precise_bus.tick) begin
            precise_timer_reg <= '0;
        end else begin
            precise_timer_reg <= precise_timer_reg + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst || heat_bus.tick) begin
            heat_timer_reg <= '0;
        end else begin
            heat_timer_reg <= heat_timer_reg + 1'b1;
        end
    end

    assign quick_tick = (quick_timer_reg == QUICK_LAST);
    assign precise_bus.tick = (precise_timer_reg == PRECISE_LAST);
    assign heat_bus.tick = (heat_timer_reg == HEAT_LAST);

    // Fast current byte: code over 255 is sense voltage over 100 mV
    always_ff @(posedge clock) begin
        if (rst) begin
            quick_current_result_reg <= BYTE_RESET;
        end else if (quick_tick) begin
            quick_current_result_reg <= quick_adc_code;
        end
    end

    // Precise current: code over 4095 is sense voltage over 100 mV
    assign precise_bus.sample = precise_adc_code;
    // Die temperature: code over 4095 is kelvin over 512
    assign heat_bus.sample = heat_adc_code;

    // Reading a half tells its holder that byte has gone out
    assign precise_bus.rd_low = reg_read && (reg_addr == ADDR_PRECISE_LOW);
    assign precise_bus.rd_high = reg_read && (reg_addr == ADDR_PRECISE_HIGH);
    assign heat_bus.rd_low = reg_read && (reg_addr == ADDR_HEAT_LOW);
    assign heat_bus.rd_high = reg_read && (reg_addr == ADDR_HEAT_HIGH);

    split_result_hold precise_hold (
        .clock(clock),
        .rst(rst),
        .res(precise_bus.holder)
    );

    split_result_hold heat_hold (
        .clock(clock),
        .rst(rst),
        .res(heat_bus.holder)
    );

    // Fault flags follow the detectors live, one cycle late
    always_ff @(posedge clock) begin
        if (rst) begin
            fault_flags_reg <= 3'h0;
        end else begin
            fault_flags_reg[FAULT_OVERHEAT_BIT] <= die_overheat_flag;
            fault_flags_reg[FAULT_OVERLOAD_BIT] <= output_overload_flag;
            fault_flags_reg[FAULT_SHORT_BIT] <= output_short_flag;
        end
    end

    // Inductor resistance: 14.6 mohm plus 0.8 mohm per code step
    always_ff @(posedge clock) begin
        if (rst) begin
            res_code_reg <= RES_CODE_RESET;
        end else if (reg_write && reg_addr == ADDR_RES_CODE) begin
            res_code_reg <= reg_wdata[RES_CODE_LSB +: 4];
        end
    end

    assign inductor_resistance_code = res_code_reg;

    // Unlock key is a plain byte; only its exact value opens the user area
    always_ff @(posedge clock) begin
        if (rst) begin
            nvm_unlock_key_reg <= UNLOCK_RESET;
        end else if (reg_write && reg_addr == ADDR_UNLOCK) begin
            nvm_unlock_key_reg <= reg_wdata;
        end
    end

    // Command decode; low three bits of the write are ignored anyway
    assign write_program = reg_write && (reg_addr == ADDR_PROGRAM);
    assign command_hit = reg_wdata[CMD_LSB +: 5] == NVM_PROGRAM_COMMAND;
    assign unlocked = (nvm_unlock_key_reg == NVM_UNLOCK_VALUE);
    // A command while locked or still burning starts nothing
    assign program_accept = write_program && command_hit && unlocked
        && (burn_state_reg == BURN_IDLE);
    assign burn_last = (burn_index_reg == NVM_LAST_INDEX);

    // Command field is read/write storage
    always_ff @(posedge clock) begin
        if (rst) begin
            nvm_program_command_reg <= PROGRAM_RESET[CMD_LSB +: 5];
        end else if (write_program) begin
            nvm_program_command_reg <= reg_wdata[CMD_LSB +: 5];
        end
    end

    // Done flag: cleared on accept, raised when the last byte is taken
    always_ff @(posedge clock) begin
        if (rst) begin
            nvm_program_done_reg <= PROGRAM_RESET[DONE_BIT];
        end else if (program_accept) begin
            nvm_program_done_reg <= 1'b0;
        end else if (burn_state_reg == BURN_WRITE && nvm_write_ack && burn_last) begin
            nvm_program_done_reg <= 1'b1;
        end
    end

    // Sequencer: fetch each config byte into a flop, then hold the request
    always_comb begin
        burn_state_next = burn_state_reg;
        case (burn_state_reg)
            BURN_IDLE: begin
                if (program_accept) begin
                    burn_state_next = BURN_FETCH;
                end
            end
            BURN_FETCH: begin
                burn_state_next = BURN_WRITE;
            end
            BURN_WRITE: begin
                if (nvm_write_ack) begin
                    burn_state_next = burn_last ? BURN_IDLE : BURN_FETCH;
                end
            end
            default: begin
                burn_state_next = BURN_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            burn_state_reg <= BURN_IDLE;
        end else begin
            burn_state_reg <= burn_state_next;
        end
    end

    // Walks addresses 0x00 through 0x0B in order
    always_ff @(posedge clock) begin
        if (rst) begin
            burn_index_reg <= NVM_FIRST_INDEX;
        end else if (program_accept) begin
            burn_index_reg <= NVM_FIRST_INDEX;
        end else if (burn_state_reg == BURN_WRITE && nvm_write_ack && !burn_last) begin
            burn_index_reg <= burn_index_reg + 1'b1;
        end
    end

    // The resistance byte lives here; the rest come from the config block
    always_ff @(posedge clock) begin
        if (rst) begin
            burn_data_reg <= BYTE_RESET;
        end else if (burn_state_reg == BURN_FETCH) begin
            if (burn_index_reg == ADDR_RES_CODE[3:0]) begin
                burn_data_reg <= {res_code_reg, 4'h0};
            end else begin
                burn_data_reg <= cfg_read_data;
            end
        end
    end

    assign cfg_read_index = burn_index_reg;
    assign nvm_write_req = (burn_state_reg == BURN_WRITE);
    assign nvm_write_addr = burn_index_reg;
    assign nvm_write_data = burn_data_reg;

    // Read mux; unmapped offsets and reserved bits give zero, except bit 0 of the program register, which reads 1
    always_comb begin
        case (reg_addr)
            ADDR_RES_CODE: read_mux = {res_code_reg, 4'h0};
            ADDR_QUICK: read_mux = quick_current_result_reg;
            ADDR_PRECISE_LOW: read_mux = {precise_bus.value[3:0], 4'h0};
            ADDR_PRECISE_HIGH: read_mux = precise_bus.value[11:4];
            ADDR_HEAT_LOW: read_mux = {heat_bus.value[3:0], 4'h0};
            ADDR_HEAT_HIGH: read_mux = heat_bus.value[11:4];
            ADDR_FAULTS: read_mux = {5'h00, fault_flags_reg};
            ADDR_PROGRAM: read_mux = {nvm_program_command_reg, PROGRAM_RESET[2],
                nvm_program_done_reg, PROGRAM_RESET[0]};
            ADDR_UNLOCK: read_mux = nvm_unlock_key_reg;
            default: read_mux = 8'h00;
        endcase
    end

    // Read data is registered so the serial engine sees a steady byte
    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata <= BYTE_RESET;
        end else if (reg_read) begin
            reg_rdata <= read_mux;
        end
    end

    AST_QUICK_SAMPLE: assert property (@(posedge clock) disable iff (rst)
        quick_tick |=> quick_current_result_reg == $past(quick_adc_code))
        else $error("fast current byte missed its conversion");
    AST_QUICK_HOLD: assert property (@(posedge clock) disable iff (rst)
        quick_tick |=> !quick_tick [*8])
        else $error("fast conversion ticks too close");
    AST_LOW_NIBBLE: assert property (@(posedge clock) disable iff (rst)
        reg_read && (reg_addr == ADDR_PRECISE_LOW || reg_addr == ADDR_HEAT_LOW)
        |=> reg_rdata[3:0] == 4'h0)
        else $error("reserved low nibble read nonzero");
    AST_HEAT_HIGH: assert property (@(posedge clock) disable iff (rst)
        reg_read && reg_addr == ADDR_HEAT_HIGH |=> reg_rdata == $past(heat_bus.value[11:4]))
        else $error("temperature high byte wrong");
    AST_FAULT_MAP: assert property (@(posedge clock) disable iff (rst)
        1'b1 |=> fault_flags_reg == $past({output_short_flag, output_overload_flag,
        die_overheat_flag}))
        else $error("fault flags do not follow detectors");
    AST_DONE_CLEAR: assert property (@(posedge clock) disable iff (rst)
        program_accept |=> !nvm_program_done_reg && burn_state_reg == BURN_FETCH)
        else $error("accepted command did not clear done");
    AST_LOCKED_IGNORE: assert property (@(posedge clock) disable iff (rst)
        write_program && command_hit && !unlocked && burn_state_reg == BURN_IDLE
        |=> burn_state_reg == BURN_IDLE && $stable(nvm_program_done_reg))
        else $error("locked program command was acted on");
    AST_BURN_END: assert property (@(posedge clock) disable iff (rst)
        nvm_write_req && nvm_write_ack && burn_last
        |=> nvm_program_done_reg && !nvm_write_req)
        else $error("done not raised after last byte");

    CVR_BURN: cover property (@(posedge clock) disable iff (rst)
        program_accept ##[1:200] nvm_program_done_reg);
    CVR_LOCKED: cover property (@(posedge clock) disable iff (rst)
        write_program && command_hit && !unlocked);
    CVR_FAULT: cover property (@(posedge clock) disable iff (rst)
        fault_flags_reg == 3'h7);
endmodule // telemetry_fault_nvm_regs

/* File: design/telemetry_pkg.sv */
// Constants and types for the telemetry, fault and nonvolatile program register bank
package telemetry_pkg;
    // Timing
    localparam int CLOCK_PERIOD_NS = 25;
    localparam int QUICK_PERIOD_NS = 32000;
    localparam int PRECISE_PERIOD_NS = 128000;
    localparam int QUICK_CYCLES = QUICK_PERIOD_NS / CLOCK_PERIOD_NS;
    localparam int PRECISE_CYCLES = PRECISE_PERIOD_NS / CLOCK_PERIOD_NS;
    localparam int TIMER_WIDTH = 16;

    // Register offsets and serial address
    localparam logic [7:0] SERIAL_ADDR_BYTE = 8'h60;
    localparam logic [7:0] ADDR_RES_CODE = 8'h02;
    localparam logic [7:0] ADDR_QUICK = 8'h48;
    localparam logic [7:0] ADDR_PRECISE_LOW = 8'h4A;
    localparam logic [7:0] ADDR_PRECISE_HIGH = 8'h4B;
    localparam logic [7:0] ADDR_HEAT_LOW = 8'h4E;
    localparam logic [7:0] ADDR_HEAT_HIGH = 8'h4F;
    localparam logic [7:0] ADDR_FAULTS = 8'h54;
    localparam logic [7:0] ADDR_PROGRAM = 8'h60;
    localparam logic [7:0] ADDR_UNLOCK = 8'h61;

    // Field positions
    localparam int RES_CODE_LSB = 4;
    localparam int FAULT_OVERHEAT_BIT = 0;
    localparam int FAULT_OVERLOAD_BIT = 1;
    localparam int FAULT_SHORT_BIT = 2;
    localparam int CMD_LSB = 3;
    localparam int DONE_BIT = 1;

    // Codes and reset values
    localparam logic [4:0] NVM_PROGRAM_COMMAND = 5'h12;
    localparam logic [7:0] NVM_UNLOCK_VALUE = 8'h61;
    localparam logic [3:0] NVM_LAST_INDEX = 4'hB;
    localparam logic [3:0] NVM_FIRST_INDEX = 4'h0;
    localparam logic [7:0] PROGRAM_RESET = 8'h01;
    localparam logic [7:0] UNLOCK_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [11:0] RESULT_RESET = 12'h000;
    localparam logic [3:0] RES_CODE_RESET = 4'h0;

    // Scaling of results, for software: full code against full scale
    localparam int SENSE_FULL_SCALE_MV = 100;
    localparam int QUICK_FULL_CODE = 255;
    localparam int PRECISE_FULL_CODE = 4095;
    localparam int HEAT_FULL_SCALE_K = 512;
    localparam int RES_BASE_TENTH_MOHM = 146;
    localparam int RES_STEP_TENTH_MOHM = 8;

    // Program sequencer states
    typedef enum logic [2:0] {
        BURN_IDLE = 3'b001,
        BURN_FETCH = 3'b010,
        BURN_WRITE = 3'b100
    } burn_state_t;
endpackage

/* File: design/split_result_if.sv */
// Carrier between the register bank and a split 12-bit result holder
`timescale 1ns/1ps
interface split_result_if;
    logic [11:0] sample;
    logic tick;
    logic rd_low;
    logic rd_high;
    logic [11:0] value;
    modport owner (output sample, output tick, output rd_low, output rd_high, input value);
    modport holder (input sample, input tick, input rd_low, input rd_high, output value);
endinterface

/* File: design/split_result_hold.sv */
// Holder for one split 12-bit conversion result with read-both-bytes reload gating
`timescale 1ns/1ps
module split_result_hold
    import telemetry_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Result path
    split_result_if.holder res
);
    logic [11:0] value_reg;
    logic [11:0] pending_reg;
    logic pending_reg_valid;
    logic low_seen_reg;
    logic high_seen_reg;
    logic armed;

    // Both halves of the shown value have gone out to the host
    assign armed = low_seen_reg && high_seen_reg;
    assign res.value = value_reg;

    // Newest conversion waits here until the host has taken the old pair
    always_ff @(posedge clock) begin
        if (rst) begin
            pending_reg <= RESULT_RESET;
            pending_reg_valid <= 1'b0;
        end else if (res.tick) begin
            pending_reg <= res.sample;
            pending_reg_valid <= 1'b1;
        end else if (armed) begin
            pending_reg_valid <= 1'b0;
        end
    end

    // Shown value moves only when both bytes were read
    always_ff @(posedge clock) begin
        if (rst) begin
            value_reg <= RESULT_RESET;
        end else if (armed && pending_reg_valid) begin
            value_reg <= pending_reg;
        end
    end

    // Read tracking; armed after reset so the first conversion shows at once
    always_ff @(posedge clock) begin
        if (rst) begin
            low_seen_reg <= 1'b1;
            high_seen_reg <= 1'b1;
        end else if (armed && pending_reg_valid) begin
            low_seen_reg <= 1'b0; // A read in this cycle returned the old value
            high_seen_reg <= 1'b0;
        end else begin
            low_seen_reg <= low_seen_reg || res.rd_low;
            high_seen_reg <= high_seen_reg || res.rd_high;
        end
    end

    AST_HOLD_FROZEN: assert property (@(posedge clock) disable iff (rst)
        !armed |=> $stable(value_reg))
        else $error("split result changed before both bytes were read");
    AST_HOLD_LOAD: assert property (@(posedge clock) disable iff (rst)
        armed && pending_reg_valid |=> value_reg == $past(pending_reg) && !armed)
        else $error("armed split result did not take the pending conversion");
    CVR_HOLD_RELOAD: cover property (@(posedge clock) disable iff (rst)
        !armed ##[1:20] armed && pending_reg_valid);
endmodule // split_result_hold

/* File: bench/nvm_model.sv */
// Behavioural nonvolatile memory that takes bytes from the burn sequencer
`timescale 1ns/1ps
module nvm_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Pace chosen by the bench
    input wire logic slow,
    // Write port of the sequencer
    input wire logic req,
    input wire logic [3:0] addr,
    input wire logic [7:0] data,
    output logic ack
);
    logic [7:0] mem [16];
    logic [2:0] wait_reg;
    int count;
    logic order_bad;

    // Ack at once or after a long wait; dropped right after the accepting edge
    always_ff @(posedge clock) begin
        if (rst) begin
            ack <= 1'b0;
            wait_reg <= 3'h0;
        end else if (ack) begin
            ack <= 1'b0;
            wait_reg <= 3'h0;
        end else if (req) begin
            if (!slow || wait_reg == 3'h5) begin
                ack <= 1'b1;
            end else begin
                wait_reg <= wait_reg + 3'h1;
            end
        end
    end

    // Store each accepted byte; bytes must arrive in ascending order
    always_ff @(posedge clock) begin
        if (rst) begin
            count <= 0;
            order_bad <= 1'b0;
        end else if (req && ack) begin
            mem[addr] <= data;
            count <= count + 1;
            if (int'(addr) != count % 12) begin
                order_bad <= 1'b1;
            end
        end
    end
endmodule // nvm_model

/* File: bench/telemetry_fault_nvm_regs_tb.sv */
// Self-checking bench for the telemetry, fault and program register bank
`timescale 1ns/1ps
module telemetry_fault_nvm_regs_tb
    import telemetry_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] quick_code = 8'h00;
    logic [11:0] prec_code = 12'h000;
    logic [11:0] heat_code = 12'h000;
    logic [2:0] flags = 3'h0;
    logic [3:0] cfg_idx;
    logic [3:0] ind_code;
    logic req;
    logic [3:0] waddr;
    logic [7:0] wdata;
    logic ack;
    logic slow = 1'b0;
    logic [7:0] cfg_rom [16];
    logic [7:0] q [$];
    logic [31:0] rnd = 32'h0001639A;
    logic [11:0] a, b, c, d;
    logic [7:0] rc;
    logic [7:0] ra [10] = '{8'h4A, 8'h4B, 8'h4E, 8'h4F, 8'h54, 8'h60, 8'h61, 8'h02, 8'h48, 8'h70};
    int err_total = 0;
    int checked = 0;

    // 40 MHz clock
    always #12.5 clock = ~clock;

    // Short conversion periods keep the run brief
    telemetry_fault_nvm_regs #(.PRECISE_PERIOD_CYCLES(16), .HEAT_PERIOD_CYCLES(16)) dut (
        .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .quick_adc_code(quick_code), .precise_adc_code(prec_code), .heat_adc_code(heat_code),
        .die_overheat_flag(flags[0]), .output_overload_flag(flags[1]),
        .output_short_flag(flags[2]), .cfg_read_index(cfg_idx),
        .cfg_read_data(cfg_rom[cfg_idx]), .inductor_resistance_code(ind_code),
        .nvm_write_req(req), .nvm_write_addr(waddr), .nvm_write_data(wdata),
        .nvm_write_ack(ack)
    );

    nvm_model nvm (
        .clock(clock), .rst(rst), .slow(slow), .req(req), .addr(waddr), .data(wdata),
        .ack(ack)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic results();
        if (err_total == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Strobes are left up so reads and writes can run back to back
    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        @(negedge clock);
        reg_write = 1'b0;
        reg_addr = ad;
        reg_read = 1'b1;
        q.push_back(e);
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        @(negedge clock);
        reg_read = 1'b0;
        reg_addr = ad;
        reg_wdata = dt;
        reg_write = 1'b1;
    endtask

    task automatic idle();
        @(negedge clock);
        reg_read = 1'b0;
        reg_write = 1'b0;
    endtask

    task automatic pause(input int n);
        repeat (n) @(negedge clock);
    endtask

    // Read data lands one edge after the strobe; compare it half a cycle later
    always @(posedge clock) begin
        if (reg_read === 1'b1) begin
            @(negedge clock);
            check8(reg_rdata, q.pop_front());
        end
    end

    // A hang is cut short here
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        results();
    end

    // Main sequence
    initial begin
        rnd = lfsr(rnd);
        a = rnd[11:0];
        b = rnd[23:12];
        rnd = lfsr(lfsr(rnd));
        c = rnd[11:0];
        d = rnd[27:16];
        prec_code = a;
        heat_code = c;
        quick_code = rnd[7:0] | 8'h01;
        pause(6);
        rst = 1'b0;
        foreach (ra[i]) rd(ra[i], (ra[i] == 8'h60) ? 8'h01 : 8'h00);
        idle();
        pause(20);
        rd(ADDR_PRECISE_LOW, {a[3:0], 4'h0});
        rd(ADDR_HEAT_HIGH, c[11:4]);
        prec_code = b;
        heat_code = d;
        idle();
        pause(40);
        rd(ADDR_PRECISE_LOW, {a[3:0], 4'h0});
        rd(ADDR_PRECISE_HIGH, a[11:4]);
        rd(ADDR_HEAT_HIGH, c[11:4]);
        rd(ADDR_HEAT_LOW, {c[3:0], 4'h0});
        idle();
        pause(40);
        rd(ADDR_PRECISE_HIGH, b[11:4]);
        rd(ADDR_PRECISE_LOW, {b[3:0], 4'h0});
        rd(ADDR_HEAT_LOW, {d[3:0], 4'h0});
        rd(ADDR_HEAT_HIGH, d[11:4]);
        idle();
        // Every combination of the three detector levels
        for (int k = 0; k < 8; k++) begin
            flags = 3'(k);
            pause(3);
            rd(ADDR_FAULTS, {5'h00, flags});
            idle();
        end
        flags = 3'h0;
        wr(ADDR_FAULTS, 8'hFF);
        wr(8'h70, 8'h5A);
        wr(ADDR_PRECISE_LOW, 8'hFF);
        idle();
        pause(2);
        rd(ADDR_FAULTS, 8'h00);
        rd(8'h70, 8'h00);
        rd(ADDR_PRECISE_LOW, {b[3:0], 4'h0});
        idle();
        rnd = lfsr(rnd);
        rc = rnd[7:0] | 8'h10;
        wr(ADDR_RES_CODE, rc);
        idle();
        pause(2);
        check8({4'h0, ind_code}, {4'h0, rc[7:4]});
        rd(ADDR_RES_CODE, {rc[7:4], 4'h0});
        idle();
        // Locked memory, near-miss key: the command field is kept but no burn starts
        wr(ADDR_UNLOCK, 8'h60);
        wr(ADDR_PROGRAM, 8'h90);
        idle();
        pause(30);
        check8(nvm.count[7:0], 8'h00);
        rd(ADDR_PROGRAM, 8'h91);
        wr(ADDR_UNLOCK, NVM_UNLOCK_VALUE);
        rd(ADDR_UNLOCK, 8'h61);
        // Unlocked but a wrong code: stored, yet nothing is burnt
        wr(ADDR_PROGRAM, 8'h88);
        rd(ADDR_PROGRAM, 8'h89);
        idle();
        pause(10);
        check8(nvm.count[7:0], 8'h00);
        // Slow burn with a stray command in mid-burn, then a prompt one
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 16; i++) begin
                rnd = lfsr(rnd);
                cfg_rom[i] = rnd[7:0];
            end
            slow = (p == 0);
            wr(ADDR_PROGRAM, 8'h90);
            rd(ADDR_PROGRAM, 8'h91);
            idle();
            if (p == 0) begin
                pause(10);
                wr(ADDR_PROGRAM, 8'h90);
                idle();
            end
            for (int i = 0; i < 500 && nvm.count < 12 * (p + 1); i++) @(negedge clock);
            if (nvm.count < 12 * (p + 1)) begin
                err_total++;
                results();
            end
            pause(3);
            rd(ADDR_PROGRAM, 8'h93);
            idle();
            pause(20);
            check8({7'h00, nvm.order_bad}, 8'h00);
            check8(nvm.count[7:0], p ? 8'h18 : 8'h0C);
            for (int i = 0; i < 12; i++) begin
                check8(nvm.mem[i], (i == 2) ? {rc[7:4], 4'h0} : cfg_rom[i]);
            end
        end
        // Fast current result refreshes on its own period
        for (int k = 0; k < 2; k++) begin
            rnd = lfsr(rnd);
            quick_code = ~quick_code ^ {rnd[7:1], 1'b0}; // Always differs from the old code
            pause(1290);
            rd(ADDR_QUICK, quick_code);
            idle();
        end
        pause(2);
        results();
    end
endmodule // telemetry_fault_nvm_regs_tb
